// ===== rtl/ts_coder_pkg.sv
package ts_coder_pkg;

    localparam logic [7:0]  PKT_LEN     = 8'hBC;    // 188 information bytes
    localparam logic [7:0]  CW_LAST     = 8'hCB;    // 204-byte codeword, last index
    localparam int          PAR_LEN     = 16;
    localparam int          SHORT_ZEROS = 51;
    localparam logic [7:0]  FIELD_POLY  = 8'h1D;    // x^8+x^4+x^3+x^2+1, x^8 implied
    localparam logic [7:0]  ROOT_BASE   = 8'h02;
    localparam logic [14:0] PRBS_INIT   = 15'h4A80; // 100101010000000, stage 1 at top
    localparam logic [2:0]  GRP_FIRST   = 3'h0;
    localparam logic [7:0]  SYNC_INV    = 8'hFF;

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            p = {p[6:0], 1'b0} ^ (p[7] ? FIELD_POLY : 8'h00);
            if (b[i]) begin
                p = p ^ a;
            end
        end
        return p;
    endfunction : gf_mul

    // Coefficient k of the product of (x + 2^i), i = 0..15
    function automatic logic [7:0] gen_coef(input int k);
        logic [7:0] g [0:PAR_LEN];
        logic [7:0] root;
        for (int i = 0; i <= PAR_LEN; i++) begin
            g[i] = 8'h00;
        end
        g[0] = 8'h01;
        root = 8'h01;
        for (int i = 0; i < PAR_LEN; i++) begin
            for (int m = i + 1; m >= 1; m--) begin
                g[m] = g[m-1] ^ gf_mul(g[m], root);
            end
            g[0] = gf_mul(g[0], root);
            root = gf_mul(root, ROOT_BASE);
        end
        return g[k];
    endfunction : gen_coef

    // Eight PRBS steps, first output bit lands on the byte MSB
    function automatic logic [22:0] prbs_byte(input logic [14:0] s);
        logic [7:0]  bits;
        logic [14:0] p;
        logic        fb;
        p = s;
        bits = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            fb = p[1] ^ p[0];
            bits[i] = fb;
            p = {fb, p[14:1]};
        end
        return {bits, p};
    endfunction : prbs_byte

endpackage : ts_coder_pkg

// ===== rtl/cable_ts_channel_coder.sv
`timescale 1ns/1ps
// Operation
// RL1: Source sends 188-byte packets: sync 0x47, three header, 184 payload bytes.
// RL2: Bytes are processed MSB first, starting with the sync byte.
// RL3: Randomiser is a 15-stage PRBS with feedback 1 + X^14 + X^15.
// RL4: Generator reloads 100101010000000 at the start of each eight-packet group.
// RL5: First sync byte of each group is inverted, 0x47 becomes 0xB8.
// RL6: First PRBS bit scrambles the first bit after the inverted sync.
// RL7: Other seven sync bytes pass unscrambled while the PRBS keeps running.
// RL8: Randomising continues whatever the input format.
// RL9: RS encode each packet, 16 parity bytes, roots powers of 2, given field.
// RL10: Shortened code acts as 51 leading zeros into a (255,239) encoder.
// RL11: Parity covers the sync byte, inverted or not.
// RL12: Interleaver has 12 branches; branch j delays 17*j bytes.
// RL13: Bytes feed branches cyclically; input and output switches move together.
// RL14: Every sync byte goes through zero-delay branch 0.
// RL15: Output keeps sync bytes exactly 204 bytes apart.
// RL16: Receiver reverses branch delays and may sync on first sync byte.
// RL17: Reset clears branch storage, commutators to 0, group count to first.
// RL18: One byte per clock with valid and start; state advances only on valid. The 16 parity slots step without valid while ready_out is low.
module cable_ts_channel_coder
    import ts_coder_pkg::*;
#(
    parameter int BRANCHES   = 12,
    parameter int CELL_DEPTH = 17
) (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] data_in,
    input  wire logic       valid_in,
    input  wire logic       start_in,
    output logic            ready_out,
    output logic [7:0]      data_out,
    output logic            valid_out,
    output logic            sync_out
);

    localparam int BR_W = $clog2(BRANCHES);
    localparam logic [BR_W-1:0] BR_LAST = BR_W'(BRANCHES - 1);

    logic [7:0]      pos_ff;
    logic [2:0]      grp_ff;
    logic [14:0]     prbs_ff;
    logic [7:0]      rs_ff [0:PAR_LEN-1];
    logic [7:0]      nxt_rs [0:PAR_LEN-1];
    logic [BR_W-1:0] br_ff;
    logic [BR_W-1:0] br_use;
    logic            take;
    logic            step;
    logic            is_sync;
    logic            is_first;
    logic [7:0]      prbs_bits;
    logic [14:0]     prbs_adv;
    logic [7:0]      sc_byte;
    logic [7:0]      fb;
    logic [7:0]      code_byte;
    logic [7:0]      tap [0:BRANCHES-1];

    // Parity slots stall the source instead of buffering it
    assign ready_out = (pos_ff < PKT_LEN);
    assign take      = valid_in && ready_out;               // [RL18]
    assign step      = take || !ready_out;
    // Free-running position keeps sync slots even without a start marker
    assign is_sync   = take && ((pos_ff == 8'h00) || start_in); // [RL8]
    assign is_first  = is_sync && (grp_ff == GRP_FIRST);

    always_comb begin
        {prbs_bits, prbs_adv} = prbs_byte(prbs_ff);          // [RL3] [RL2]
        if (is_first) begin
            sc_byte = data_in ^ SYNC_INV;                   // [RL5]
        end else if (is_sync) begin
            sc_byte = data_in;                              // [RL7]
        end else begin
            sc_byte = data_in ^ prbs_bits;                  // [RL6] [RL8]
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prbs_ff <= PRBS_INIT;
        end else if (is_first) begin
            prbs_ff <= PRBS_INIT;                           // [RL4]
        end else if (take) begin
            prbs_ff <= prbs_adv;                            // [RL7]
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pos_ff <= 8'h00;
        end else if (take && start_in) begin
            pos_ff <= 8'h01;
        end else if (step) begin
            pos_ff <= (pos_ff == CW_LAST) ? 8'h00 : pos_ff + 8'h01;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            grp_ff <= GRP_FIRST;                            // [RL17]
        end else if (is_sync) begin
            grp_ff <= grp_ff + 3'h1;
        end
    end

    // Zero register at each sync equals running the 51 zero prefix bytes
    assign fb = sc_byte ^ (is_sync ? 8'h00 : rs_ff[PAR_LEN-1]); // [RL10] [RL11]

    for (genvar i = 0; i < PAR_LEN; i++) begin : g_rs
        localparam logic [7:0] GC = gen_coef(i);
        logic [7:0] prev;
        if (i == 0) begin : g_lo
            assign prev = 8'h00;
        end else begin : g_hi
            assign prev = rs_ff[i-1];
        end
        always_comb begin
            if (take) begin
                nxt_rs[i] = (is_sync ? 8'h00 : prev) ^ gf_mul(fb, GC); // [RL9]
            end else begin
                nxt_rs[i] = prev;
            end
        end
        always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
                rs_ff[i] <= 8'h00;
            end else if (step) begin
                rs_ff[i] <= nxt_rs[i];
            end
        end
    end

    assign code_byte = take ? sc_byte : rs_ff[PAR_LEN-1];   // [RL9]

    // Sync always forced onto branch 0 so a late start marker cannot misplace it
    assign br_use = is_sync ? '0 : br_ff;                   // [RL14]

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            br_ff <= '0;                                    // [RL17]
        end else if (step) begin
            br_ff <= (br_use == BR_LAST) ? '0 : br_use + 1'b1; // [RL13]
        end
    end

    assign tap[0] = code_byte;                              // [RL14]

    for (genvar j = 1; j < BRANCHES; j++) begin : g_branch
        localparam int DEPTH = CELL_DEPTH * j;
        logic [7:0] cell_ff [0:DEPTH-1];
        always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
                for (int k = 0; k < DEPTH; k++) begin
                    cell_ff[k] <= 8'h00;                    // [RL17]
                end
            end else if (step && (br_use == BR_W'(j))) begin
                cell_ff[0] <= code_byte;                    // [RL12]
                for (int k = 1; k < DEPTH; k++) begin
                    cell_ff[k] <= cell_ff[k-1];
                end
            end
        end
        assign tap[j] = cell_ff[DEPTH-1];
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            data_out  <= 8'h00;
            valid_out <= 1'b0;
            sync_out  <= 1'b0;
        end else begin
            data_out  <= tap[br_use];                       // [RL13]
            valid_out <= step;
            sync_out  <= is_sync;                           // [RL15]
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    property p_group_load;
        is_first |=> prbs_ff == PRBS_INIT;
    endproperty
    a_group_load: assert property (p_group_load) // [RL4]
        else $error("PRBS not reloaded at group start");

    property p_sync_invert;
        is_first |-> code_byte == ~data_in;
    endproperty
    a_sync_invert: assert property (p_sync_invert) // [RL5]
        else $error("First sync byte not inverted");

    property p_sync_plain;
        (is_sync && !is_first) |-> code_byte == data_in ##1 prbs_ff != $past(prbs_ff);
    endproperty
    a_sync_plain: assert property (p_sync_plain) // [RL7]
        else $error("Later sync byte altered or PRBS halted");

    property p_prbs_shift;
        (take && !is_first) |=> prbs_ff[6:0] == $past(prbs_ff[14:8]);
    endproperty
    a_prbs_shift: assert property (p_prbs_shift) // [RL3]
        else $error("PRBS did not advance eight stages");

    property p_parity_len;
        $fell(ready_out) |-> (!ready_out)[*8] ##1 (!ready_out)[*8] ##1 ready_out;
    endproperty
    a_parity_len: assert property (p_parity_len) // [RL9]
        else $error("Parity phase is not sixteen bytes");

    property p_sync_branch;
        sync_out |-> $past(br_use) == '0 && valid_out;
    endproperty
    a_sync_branch: assert property (p_sync_branch) // [RL14]
        else $error("Sync byte left branch 0");

    property p_commutate;
        (step && !is_sync) |=> br_ff == (($past(br_ff) == BR_LAST) ? '0 : $past(br_ff) + 1'b1);
    endproperty
    a_commutate: assert property (p_commutate) // [RL13]
        else $error("Commutator skipped a branch");

    property p_hold_idle;
        (ready_out && !valid_in) |=> $stable(prbs_ff) && $stable(pos_ff) && !valid_out;
    endproperty
    a_hold_idle: assert property (p_hold_idle) // [RL18]
        else $error("State moved without valid strobe");

    property p_reset_state;
        $past(rst_in) |-> pos_ff == 8'h00 && br_ff == '0 && grp_ff == GRP_FIRST;
    endproperty
    a_reset_state: assert property (p_reset_state) // [RL17]
        else $error("Reset state not restored");

endmodule : cable_ts_channel_coder

// ===== dv/ts_source.sv
`timescale 1ns/1ps
module ts_source #(
    parameter int NPKT = 14
) (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       ready_in,
    output logic [7:0]      data_out,
    output logic            valid_out,
    output logic            start_out
);
    int   pos = 0;
    int   npk = 0;
    logic tk  = 1'b0;

    initial begin
        data_out = 8'h00;
        valid_out = 1'b0;
        start_out = 1'b0;
    end

    // Take decided before the edge, so the edge itself is never raced
    always @(negedge clock_in) tk = valid_out && ready_in;

    always @(posedge clock_in) begin
        #2;
        if (tk) begin
            pos = (pos == 187) ? 0 : pos + 1;
            npk = (pos == 0) ? npk + 1 : npk;
        end
        if (tk || !valid_out) begin
            if (rst_in || npk >= NPKT || $urandom % 4 == 0) begin
                valid_out = 1'b0;
                start_out = 1'b0;
                data_out = ~data_out;
            end else begin
                valid_out = 1'b1;
                start_out = (pos == 0);
                data_out = (pos == 0) ? 8'h47 : 8'($urandom);
            end
        end
    end
endmodule : ts_source

// ===== dv/cable_ts_channel_coder_tb.sv
`timescale 1ns/1ps
module cable_ts_channel_coder_tb;
    import ts_coder_pkg::*;
    localparam int NPKT = 14;
    logic       clock_in = 1'b0;
    logic       rst_in   = 1'b1;
    logic [7:0] data_in;
    logic       valid_in;
    logic       start_in;
    logic       ready_out;
    logic [7:0] data_out;
    logic       valid_out;
    logic       sync_out;
    int         n_mismatch   = 0;
    int         total_checks = 0;
    int         s            = 0;
    int         j;
    int         src;
    logic [9:0] n;
    logic [1:15] r   = 15'b100101010000000;
    logic [2:0]  grp = GRP_FIRST;
    logic [7:0]  cw [0:4095];
    logic        kn [0:4095];
    logic [9:0]  q [$];
    int          qs [$];
    int          sp;
    logic [7:0]  cwo [0:4095];

    always #12.5 clock_in = ~clock_in;

    ts_source #(.NPKT(NPKT)) i_ts_source (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .ready_in  (ready_out),
        .data_out  (data_in),
        .valid_out (valid_in),
        .start_out (start_in)
    );

    cable_ts_channel_coder i_cable_ts_channel_coder (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .data_in   (data_in),
        .valid_in  (valid_in),
        .start_in  (start_in),
        .ready_out (ready_out),
        .data_out  (data_out),
        .valid_out (valid_out),
        .sync_out  (sync_out)
    );

    function automatic logic [7:0] prbs8();
        logic [7:0] b;
        for (int i = 7; i >= 0; i--) begin
            b[i] = r[14] ^ r[15];
            r = {b[i], r[1:14]};
        end
        return b;
    endfunction : prbs8

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Field product worked low bit first, apart from the coder's own arithmetic
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ a;
            end
            a = {a[6:0], 1'b0} ^ (a[7] ? FIELD_POLY : 8'h00);
        end
        return p;
    endfunction : gmul

    // Every fully seen codeword must vanish at all 16 roots; zero prefix adds nothing
    task automatic rs_check();
        logic [7:0] sy;
        logic [7:0] a;
        a = 8'h01;
        for (int i = 0; i < PAR_LEN; i++) begin
            for (int c = 0; 204 * c + 203 + 204 * 11 < s; c++) begin
                sy = 8'h00;
                for (int p = 0; p < 204; p++) begin
                    sy = gmul(sy, a) ^ cwo[204 * c + p];
                end
                chk("syndrome", 8'h00, sy);
            end
            a = gmul(a, ROOT_BASE);
        end
    endtask : rs_check

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // One note per output slot; parity slots carry no known value
    always @(negedge clock_in) begin
        if (!rst_in) chk("ready_out", 8'(s % 204 < 188), 8'(ready_out));
        if (!rst_in && (!ready_out || valid_in)) begin
            kn[s] = ready_out;
            if (ready_out && s % 204 == 0) begin
                cw[s] = (grp == GRP_FIRST) ? ~data_in : data_in;
                if (grp == GRP_FIRST) r = 15'b100101010000000;
                else void'(prbs8());
                grp = grp + 3'h1;
            end else if (ready_out) begin
                cw[s] = data_in ^ prbs8();
            end
            j = s % 12;
            src = s - 204 * j;
            q.push_back({src < 0 || kn[src], s % 204 == 0, (src < 0) ? 8'h00 : cw[src]});
            qs.push_back(src);
            s++;
        end
    end

    always @(negedge clock_in) begin
        if (valid_out === 1'b1) begin
            chk("queue", 8'h01, 8'(q.size() > 0));
            n = (q.size() > 0) ? q.pop_front() : 10'h000;
            sp = (qs.size() > 0) ? qs.pop_front() : -1;
            // Receiver view: branch j byte belongs 204*j slots back
            if (sp >= 0) cwo[sp] = data_out;
            chk("sync_out", {7'h00, n[8]}, {7'h00, sync_out});
            if (n[9]) chk("data_out", n[7:0], data_out);
        end
    end

    initial begin
        void'($urandom(32'hB3A5));
        repeat (10) @(posedge clock_in);
        #2 rst_in = 1'b0;
        wait (s >= NPKT * 204);
        repeat (5) @(posedge clock_in);
        chk("left", 8'h00, 8'(q.size()));
        rs_check();
        final_report();
    end

    // Roughly 1.4 cycles a byte with idle gaps; twice that is ample
    initial begin
        #(25 * 8000);
        n_mismatch++;
        final_report();
    end
endmodule : cable_ts_channel_coder_tb
